/* include/usart_consts.vh */
// constants for the serial transceiver: offsets, fields, parity codes, timing, bus responses
`ifndef USART_CONSTS_VH
`define USART_CONSTS_VH
`define OFF_LINE_CTRL 8'h00
`define OFF_RX_STATUS 8'h04
`define OFF_INT_CLOCK 8'h08
`define OFF_TX_BUF 8'h0c
`define OFF_RX_BUF 8'h10
`define OFF_BAUD_DIV 8'h14
`define OFF_PRESCALE 8'h18
`define OFF_POWER 8'h1c
`define LC_PARITY_SEL_HIGH 7
`define LC_PARITY_SEL_LOW 6
`define LC_PARITY_ENABLE 5
`define LC_FRAME_HIGH 4
`define LC_FRAME_LOW 3
`define LC_TX_EMPTY 1
`define LC_RX_FULL 0
`define IC_TWO_STOP 7
`define IC_SYNC_MODE 4
`define IC_RX_EXT 3
`define IC_TX_EXT 2
`define IC_RX_IE 1
`define IC_TX_IE 0
`define RS_OVERRUN 7
`define RS_FRAMING 6
`define RS_PARITY 5
`define RS_RX_NINTH 3
`define RS_TX_BUSY 1
`define PAR_ODD 2'b00
`define PAR_EVEN 2'b01
`define PAR_MARK 2'b10
`define PAR_SPACE 2'b11
`define WAKE_SETTLE_CYCLES 16'h0100
`define OVERSAMPLE 5'h10
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`endif

/* sim/serial_station.sv */
// remote serial station: sends, glitches and samples frames on the line pins
`timescale 1ns/1ps
module serial_station #(parameter int BIT_CYC = 64) (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  initial line_o = 1'b1;
  // start bit, then n bits lsb first; the caller ends with one stop bit
  task automatic send(input logic [11:0] v, input int n);
    @(posedge clk_i);
    line_o <= 1'b0;
    repeat (BIT_CYC) @(posedge clk_i);
    for (int i = 0; i < n; i++)
    begin
      line_o <= v[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask
  // low pulse shorter than half a bit
  task automatic glitch(input int c);
    @(posedge clk_i);
    line_o <= 1'b0;
    repeat (c) @(posedge clk_i);
    line_o <= 1'b1;
  endtask
  // mid-bit samples of n bits after start; rest read one
  task automatic recv(input int n, output logic [11:0] v);
    v = 12'hfff;
    while (line_i !== 1'b0) @(posedge clk_i);
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++)
    begin
      repeat (BIT_CYC) @(posedge clk_i);
      v[i] = line_i;
    end
  endtask
endmodule

/* sim/tb.sv */
// testbench: bus tasks and one task per scenario
`timescale 1ns/1ps
`include "usart_consts.vh"
module tb;
  localparam int BIT_CYC = 64;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic halt_enter_i = 1'b0;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic rx_line, tx_line, sck_o, sck_oe, tx_irq, rx_irq, wake, run_en;
  int failures = 0;
  int checks = 0;
  // clock pin pulled low when not driven
  wire sck_pin = sck_oe ? sck_o : 1'b0;
  always #4 clk_i = ~clk_i;
  usart_sync_framing_baud usart_sync_framing_baud_i (
    .clk_i(clk_i), .reset_i(reset_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .halt_enter_i(halt_enter_i), .receive_data_pin_i(rx_line), .transmit_data_pin_o(tx_line),
    .serial_clock_pin_i(sck_pin), .serial_clock_pin_o(sck_o), .serial_clock_pin_oe_o(sck_oe),
    .tx_irq_o(tx_irq), .rx_irq_o(rx_irq), .wake_o(wake), .run_enable_o(run_en)
  );
  serial_station #(.BIT_CYC(BIT_CYC)) serial_station_i (.clk_i(clk_i), .line_i(tx_line), .line_o(rx_line));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge clk_i);
      aw |= s_axi_awready;
      w |= s_axi_wready;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk_i);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk_i);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, d, e);
  endtask
  task automatic wait_rx();
    while (rx_irq !== 1'b1) @(posedge clk_i);
  endtask
  function automatic logic [11:0] frm7(input logic [6:0] d, input logic [1:0] kind);
    logic p;
    p = kind[1] ? ~kind[0] : (kind[0] ? ^d : ~^d);
    return {4'hf, p, d};
  endfunction
  task automatic t_reset_vals();
    logic [31:0] d;
    logic [1:0] r;
    rc(`OFF_LINE_CTRL, 32'h2, "line_ctrl");
    rc(`OFF_INT_CLOCK, 32'h0, "int_clock");
    chk("tx_irq_rst", tx_irq, 32'h0);
    rd(8'h20, d, r);
    chk("unmapped_data", d, 32'h0);
    chk("unmapped_resp", r, `AXI_SLVERR);
    wr(`OFF_TX_BUF, 32'h0);
    repeat (200) @(posedge clk_i);
    chk("tx_stopped", tx_line, 32'h1);
    wr(`OFF_BAUD_DIV, 32'h1); // rate set while stopped
    wr(`OFF_PRESCALE, 32'h18); // factor 2, divisor 2
    repeat (BIT_CYC * 12) @(posedge clk_i);
  endtask
  task automatic t_tx_parity();
    logic [11:0] g1, g2;
    logic [6:0] a, b;
    for (int k = 0; k < 4; k++)
    begin
      a = 7'h35 ^ k[6:0];
      b = 7'h4a + k[6:0];
      wr(`OFF_LINE_CTRL, 32'h28 | (k << 6));
      wr(`OFF_INT_CLOCK, 32'h1 | ((k & 1) << 7));
      fork
        begin
          wr(`OFF_TX_BUF, {25'h0, a});
          while (tx_irq !== 1'b1) @(posedge clk_i);
          wr(`OFF_TX_BUF, {25'h0, b});
        end
        begin
          serial_station_i.recv(9 + (k & 1), g1);
          serial_station_i.recv(9 + (k & 1), g2);
        end
      join
      chk("tx_frame_a", g1, frm7(a, k[1:0]));
      chk("tx_frame_b", g2, frm7(b, k[1:0]));
      chk("tx_irq_on", tx_irq, 32'h1);
    end
    wr(`OFF_INT_CLOCK, 32'h0);
    @(posedge clk_i);
    chk("tx_irq_off", tx_irq, 32'h0);
  endtask
  task automatic t_tx_nine();
    logic [11:0] g;
    wr(`OFF_LINE_CTRL, 32'h70);
    fork
      wr(`OFF_TX_BUF, 32'ha5);
      serial_station_i.recv(10, g);
    join
    chk("tx_nine", g, 12'hfa5);
  endtask
  task automatic t_rx();
    wr(`OFF_LINE_CTRL, 32'h0);
    wr(`OFF_INT_CLOCK, 32'h82);
    serial_station_i.glitch(BIT_CYC / 4);
    repeat (BIT_CYC) @(posedge clk_i);
    serial_station_i.send(12'h13c, 9);
    wait_rx();
    chk("rx_irq_on", rx_irq, 32'h1);
    rc(`OFF_RX_STATUS, 32'h0, "rx_status");
    rc(`OFF_RX_BUF, 32'h3c, "rx_data");
    @(posedge clk_i);
    chk("rx_irq_off", rx_irq, 32'h0);
    wr(`OFF_LINE_CTRL, 32'h10);
    serial_station_i.send(12'h3c3, 10);
    wait_rx();
    rc(`OFF_RX_STATUS, 32'h8, "rx_ninth");
    rc(`OFF_RX_BUF, 32'hc3, "rx_nine_data");
  endtask
  task automatic t_halt();
    int n;
    wr(`OFF_LINE_CTRL, 32'h0);
    serial_station_i.send(12'h15a, 9);
    wait_rx();
    @(posedge clk_i);
    halt_enter_i <= 1'b1;
    @(posedge clk_i);
    halt_enter_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("halted", run_en, 32'h0);
    rc(`OFF_LINE_CTRL, 32'h2, "lc_halt");
    rc(`OFF_INT_CLOCK, 32'h82, "ic_halt");
    rc(`OFF_RX_BUF, 32'h5a, "receive_buffer_kept");
    chk("rx_irq_halt", rx_irq, 32'h0);
    fork
      serial_station_i.send(12'h100, 9);
      begin
        while (wake !== 1'b1) @(posedge clk_i);
        for (n = 0; run_en !== 1'b1; n++) @(posedge clk_i);
      end
    join
    chk("settle", n >= 255 && n <= 257, 32'h1);
  endtask
  task automatic t_sync_clk();
    logic p;
    int n;
    p = 1'b0;
    n = 0;
    wr(`OFF_INT_CLOCK, 32'h10);
    wr(`OFF_POWER, 32'h1);
    @(posedge clk_i);
    chk("sck_oe_on", sck_oe, 32'h1);
    for (int i = 0; i < 80; i++)
    begin
      @(posedge clk_i);
      n += (sck_pin && !p);
      p = sck_pin;
    end
    chk("sck_rate", n >= 9 && n <= 11, 32'h1);
    wr(`OFF_POWER, 32'h0);
    @(posedge clk_i);
    chk("sck_oe_off", sck_oe, 32'h0);
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset_vals();
    t_tx_parity();
    t_tx_nine();
    t_rx();
    t_halt();
    t_sync_clk();
    summarize();
  end
  initial
  begin
    repeat (40000) @(posedge clk_i);
    failures++;
    summarize();
  end
endmodule
bind usart_sync_framing_baud usart_chk usart_chk_i (
  .clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .halt_enter_i(halt_enter_i),
  .transmit_data_pin_o(transmit_data_pin_o), .rx_irq_o(rx_irq_o), .wake_o(wake_o), .run_enable_o(run_enable_o)
);

/* sim/usart_chk.sv */
// checker: bus answers, irq clear, halt, wake, start bit
`timescale 1ns/1ps
`include "usart_consts.vh"
module usart_chk (
  input wire clk_i,
  input wire reset_i,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire halt_enter_i,
  input wire transmit_data_pin_o,
  input wire rx_irq_o,
  input wire wake_o,
  input wire run_enable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic [9:0] settle_r;
  // cycles spent stopped since the last wake pulse
  always @(posedge clk_i)
  begin
    if (reset_i || wake_o)
      settle_r <= 10'h000;
    else if (!run_enable_o && settle_r != 10'h3ff)
      settle_r <= settle_r + 10'h001;
  end
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_low8;
    !transmit_data_pin_o [*8];
  endsequence
  property p_wr_answer;
    s_wr_taken |=> s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_wr_okay;
    s_wr_taken and s_axi_awaddr <= 8'h1c && s_axi_awaddr[1:0] == 2'h0 |=> s_axi_bresp == `AXI_OKAY;
  endproperty
  a_wr_okay: assert property (p_wr_okay) else $error("mapped write refused");
  property p_rd_answer;
    s_rd_taken |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_unmapped;
    s_rd_taken and s_axi_araddr > 8'h1c |=> s_axi_rresp == `AXI_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_rx_irq_clr;
    s_rd_taken and s_axi_araddr == `OFF_RX_BUF |-> ##[1:2] !rx_irq_o;
  endproperty
  a_rx_irq_clr: assert property (p_rx_irq_clr) else $error("rx irq kept after buffer read");
  property p_wake_halted;
    wake_o |=> !run_enable_o && !wake_o;
  endproperty
  a_wake_halted: assert property (p_wake_halted) else $error("wake while running");
  property p_settle;
    $rose(run_enable_o) |-> settle_r >= 10'h0ff && settle_r <= 10'h101;
  endproperty
  a_settle: assert property (p_settle) else $error("settle wait not 256 cycles");
  property p_halt;
    halt_enter_i |-> ##[1:2] !run_enable_o;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not entered");
  property p_start_len;
    $fell(transmit_data_pin_o) |-> s_low8;
  endproperty
  a_start_len: assert property (p_start_len) else $error("short low on line");
endmodule

/* src/baud_gen.v */
// two-stage baud divider: half-step prescaler then 11-bit counter, one pulse per tick
`timescale 1ns/1ps
module baud_gen (
  input wire clk_i,
  input wire reset_i,
  input wire [4:0] prescale_i,
  input wire [10:0] divisor_i,
  output reg tick_o
);
  // half-unit accumulator prescaler
  reg [5:0] pre_acc_r;
  reg [10:0] div_cnt_r;
  wire [5:0] pre_lim = {1'b0, prescale_i} + 6'h01;
  wire pre_step = (prescale_i != 5'h00);
  wire [5:0] pre_sum = pre_acc_r + 6'h02;
  wire pre_tick = pre_step && (pre_sum >= pre_lim);
  always @(posedge clk_i)
  begin
    if (reset_i || !pre_step)
    begin
      pre_acc_r <= 6'h00;
      div_cnt_r <= 11'h000;
      tick_o <= 1'b0;
    end
    else
    begin
      // accumulate two half-units per master clock; factor (k+1)/2
      pre_acc_r <= pre_tick ? (pre_sum - pre_lim) : pre_sum;
      tick_o <= 1'b0;
      if (pre_tick)
      begin
        // divide by N = programmed value plus one
        if (div_cnt_r >= divisor_i)
        begin
          div_cnt_r <= 11'h000;
          tick_o <= 1'b1;
        end
        else
          div_cnt_r <= div_cnt_r + 11'h001;
      end
    end
  end
endmodule

/* src/parity_calc.v */
// parity bit for a 7/8-bit character under the four parity kinds
`timescale 1ns/1ps
`include "usart_consts.vh"
module parity_calc (
  input wire [7:0] data_i,
  input wire seven_i,
  input wire [1:0] kind_i,
  output reg parity_o
);
  wire ones = ^(seven_i ? {1'b0, data_i[6:0]} : data_i);
  always @*
  begin
    // odd, even, mark, space encoding
    case (kind_i)
      `PAR_ODD: parity_o = ~ones;
      `PAR_EVEN: parity_o = ones;
      `PAR_MARK: parity_o = 1'b1;
      `PAR_SPACE: parity_o = 1'b0;
      default: parity_o = 1'b0;
    endcase
  end
endmodule

/* src/usart_sync_framing_baud.v */
// serial transceiver: AXI4-Lite registers, framing, baud chain, halt
// Operation
// - sync: transmit on rising, receive falling
// - mode bit selects bit-rate synchronous clock
// - external clock pin shifts data
// - output clock pin carries baud generator
// - seven data bits, optional parity
// - eight data bits, optional parity
// - nine data bits, ninth via flags
// - parity enable only for seven/eight
// - shared bit: ninth bit or parity low
// - receiver needs only one stop bit
// - separate receive and transmit interrupts
// - tx interrupt: empty and enable
// - rx interrupt: full and enable
// - independent clock select per direction
// - half-step prescaler then 11-bit counter
// - zero prescale code stops clock
// - rate from prescaler, divisor, 16 or 2
// - halt entry reinitialises status and transmit shifter
// - start bit on receive pin wakes
// - settle wait of 256 cycles
// - parity select encoding odd/even/mark/space
// - stop control: one or two stops
// - start detect, half-bit recheck, triple sample
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "usart_consts.vh"
module usart_sync_framing_baud (
  input wire clk_i,
  input wire reset_i,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire halt_enter_i,
  input wire receive_data_pin_i,
  output reg transmit_data_pin_o,
  input wire serial_clock_pin_i,
  output wire serial_clock_pin_o,
  output wire serial_clock_pin_oe_o,
  output wire tx_irq_o,
  output wire rx_irq_o,
  output wire wake_o,
  output wire run_enable_o
);
  reg [7:0] line_ctrl_r;
  reg [7:0] int_clock_r;
  reg [7:0] transmit_buffer_r;
  reg [7:0] receive_buffer_r;
  reg [10:0] divisor_r;
  reg [4:0] prescale_r;
  reg clk_out_en_r;
  reg tx_empty_r;
  reg rx_full_r;
  reg rx_ninth_bit_r;
  reg overrun_r;
  reg framing_r;
  reg parity_err_r;
  reg tx_busy_r;
  reg [10:0] transmit_shifter_r;
  reg [3:0] tx_left_r;
  reg [4:0] tx_os_r;
  reg [9:0] receive_shifter_r;
  reg [3:0] rx_left_r;
  reg [4:0] rx_os_r;
  reg [2:0] rx_votes_r;
  reg rx_active_r;
  reg rx_prev_r;
  reg sclk_int_r;
  reg sclk_ext_prev_r;
  reg halted_r;
  reg [15:0] settle_r;
  reg [1:0] aw_hold_r;
  reg [7:0] awaddr_r;
  reg [31:0] wdata_r;
  wire baud_tick;
  wire tx_par_bit;
  wire rx_par_bit;
  wire frame_low = line_ctrl_r[`LC_FRAME_LOW];
  wire frame_high = line_ctrl_r[`LC_FRAME_HIGH];
  wire nine_bits = frame_high;
  wire seven_bits = frame_low && !frame_high;
  wire parity_on = line_ctrl_r[`LC_PARITY_ENABLE] && !nine_bits;
  // shared bit: ninth data bit or low parity select
  wire tx_ninth_bit = line_ctrl_r[`LC_PARITY_SEL_LOW];
  wire [1:0] par_kind = {line_ctrl_r[`LC_PARITY_SEL_HIGH], line_ctrl_r[`LC_PARITY_SEL_LOW]};
  wire sync_mode = int_clock_r[`IC_SYNC_MODE];
  wire [3:0] data_len = nine_bits ? 4'h9 : (seven_bits ? 4'h7 : 4'h8);
  wire [3:0] rx_len = data_len + {3'h0, parity_on} + 4'h1;
  wire ext_rise = serial_clock_pin_i && !sclk_ext_prev_r;
  wire ext_fall = !serial_clock_pin_i && sclk_ext_prev_r;
  wire int_rise = baud_tick && !sclk_int_r;
  wire int_fall = baud_tick && sclk_int_r;
  // per-direction clock source sync uses clock edges directly
  wire tx_edge = sync_mode ? (int_clock_r[`IC_TX_EXT] ? ext_rise : int_rise) : baud_tick;
  wire rx_edge = sync_mode ? (int_clock_r[`IC_RX_EXT] ? ext_fall : int_fall) : baud_tick;
  wire aw_go = s_axi_awvalid && !aw_hold_r[0];
  wire w_go = s_axi_wvalid && !aw_hold_r[1];
  wire wr_fire = (aw_hold_r[0] || aw_go) && (aw_hold_r[1] || w_go) && !s_axi_bvalid;
  wire [7:0] wr_addr = aw_hold_r[0] ? awaddr_r : s_axi_awaddr;
  wire [31:0] wr_data = aw_hold_r[1] ? wdata_r : s_axi_wdata;
  wire wr_lane = s_axi_wstrb[0];
  wire rd_fire = s_axi_arvalid && !s_axi_rvalid;
  wire transmit_buffer_write = wr_fire && wr_lane && wr_addr == `OFF_TX_BUF;
  wire receive_buffer_read = rd_fire && s_axi_araddr == `OFF_RX_BUF;
  wire stat_read = rd_fire && s_axi_araddr == `OFF_RX_STATUS;
  wire tx_load = !tx_busy_r && !tx_empty_r;
  wire [7:0] rx_data = seven_bits ? {1'b0, receive_shifter_r[6:0]} : receive_shifter_r[7:0];
  wire rx_vote = (rx_votes_r[0] & rx_votes_r[1]) | (rx_votes_r[1] & rx_votes_r[2]) | (rx_votes_r[0] & rx_votes_r[2]);
  wire rx_bit = sync_mode ? receive_data_pin_i : rx_vote;
  assign s_axi_awready = !aw_hold_r[0] && !s_axi_bvalid;
  assign s_axi_wready = !aw_hold_r[1] && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign serial_clock_pin_o = sclk_int_r;
  assign serial_clock_pin_oe_o = clk_out_en_r && sync_mode;
  // level interrupts, vectors in the cpu core
  assign tx_irq_o = tx_empty_r && int_clock_r[`IC_TX_IE];
  assign rx_irq_o = rx_full_r && int_clock_r[`IC_RX_IE];
  assign wake_o = halted_r && !receive_data_pin_i && rx_prev_r;
  assign run_enable_o = !halted_r && settle_r == 16'h0000;

  baud_gen u_baud (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .prescale_i(prescale_r),
    .divisor_i(divisor_r),
    .tick_o(baud_tick)
  );

  parity_calc u_tx_par (
    .data_i(transmit_buffer_r),
    .seven_i(seven_bits),
    .kind_i(par_kind),
    .parity_o(tx_par_bit)
  );

  parity_calc u_rx_par (
    .data_i(receive_shifter_r[7:0]),
    .seven_i(seven_bits),
    .kind_i(par_kind),
    .parity_o(rx_par_bit)
  );

  // bus slave: address and data taken in either order
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      aw_hold_r <= 2'b00;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `AXI_OKAY;
      s_axi_rdata <= 32'h00000000;
    end
    else
    begin
      if (wr_fire)
      begin
        aw_hold_r <= 2'b00;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_addr > `OFF_POWER || wr_addr[1:0] != 2'b00) ? `AXI_SLVERR : `AXI_OKAY;
      end
      else
      begin
        if (aw_go)
        begin
          aw_hold_r[0] <= 1'b1;
          awaddr_r <= s_axi_awaddr;
        end
        if (w_go)
        begin
          aw_hold_r[1] <= 1'b1;
          wdata_r <= s_axi_wdata;
        end
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `AXI_OKAY;
        case (s_axi_araddr)
          `OFF_LINE_CTRL: s_axi_rdata <= {24'h000000, line_ctrl_r[7:3], 1'b0, tx_empty_r, rx_full_r};
          `OFF_RX_STATUS: s_axi_rdata <= {24'h000000, overrun_r, framing_r, parity_err_r, 1'b0,
                                          rx_ninth_bit_r, 1'b0, tx_busy_r, rx_active_r};
          `OFF_INT_CLOCK: s_axi_rdata <= {24'h000000, int_clock_r};
          `OFF_TX_BUF: s_axi_rdata <= {24'h000000, transmit_buffer_r};
          `OFF_RX_BUF: s_axi_rdata <= {24'h000000, receive_buffer_r};
          `OFF_BAUD_DIV: s_axi_rdata <= {24'h000000, divisor_r[7:0]};
          `OFF_PRESCALE: s_axi_rdata <= {24'h000000, prescale_r, divisor_r[10:8]};
          `OFF_POWER: s_axi_rdata <= {31'h00000000, clk_out_en_r};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `AXI_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // read/write control bits; halt leaves them unchanged
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      line_ctrl_r <= 8'h00;
      int_clock_r <= 8'h00;
      transmit_buffer_r <= 8'h00;
      divisor_r <= 11'h000;
      prescale_r <= 5'h00;
      clk_out_en_r <= 1'b0;
    end
    else if (wr_fire && wr_lane)
    begin
      case (wr_addr)
        `OFF_LINE_CTRL: line_ctrl_r <= {wr_data[7:3], 3'b000};
        `OFF_INT_CLOCK: int_clock_r <= {wr_data[7], 2'b00, wr_data[4:0]};
        `OFF_TX_BUF: transmit_buffer_r <= wr_data[7:0];
        `OFF_BAUD_DIV: divisor_r[7:0] <= wr_data[7:0];
        // upper divisor bits share the prescaler register
        `OFF_PRESCALE:
        begin
          prescale_r <= wr_data[7:3];
          divisor_r[10:8] <= wr_data[2:0];
        end
        `OFF_POWER: clk_out_en_r <= wr_data[0];
        default: clk_out_en_r <= clk_out_en_r;
      endcase
    end
  end

  // halt state, wake and settle count
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      halted_r <= 1'b0;
      settle_r <= 16'h0000;
      rx_prev_r <= 1'b1;
    end
    else
    begin
      rx_prev_r <= receive_data_pin_i;
      if (halt_enter_i)
        halted_r <= 1'b1;
      else if (wake_o)
      begin
        halted_r <= 1'b0;
        settle_r <= `WAKE_SETTLE_CYCLES;
      end
      else if (settle_r != 16'h0000)
        settle_r <= settle_r - 16'h0001;
    end
  end

  // internal bit clock toggles on each baud tick in sync mode
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      sclk_int_r <= 1'b0;
      sclk_ext_prev_r <= 1'b0;
    end
    else
    begin
      sclk_ext_prev_r <= serial_clock_pin_i;
      if (baud_tick && sync_mode)
        sclk_int_r <= ~sclk_int_r;
    end
  end

  // transmitter
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      tx_empty_r <= 1'b1;
      tx_busy_r <= 1'b0;
      transmit_shifter_r <= 11'h7ff;
      tx_left_r <= 4'h0;
      tx_os_r <= 5'h00;
      transmit_data_pin_o <= 1'b1;
    end
    else if (halt_enter_i)
    begin
      tx_empty_r <= 1'b1;
      tx_busy_r <= 1'b0;
      transmit_shifter_r <= 11'h7ff;
      tx_left_r <= 4'h0;
      transmit_data_pin_o <= 1'b1;
    end
    else
    begin
      if (transmit_buffer_write)
        tx_empty_r <= 1'b0;
      if (tx_load && tx_edge)
      begin
        // data, optional parity or ninth bit, stop bits
        case (data_len)
          4'h7: transmit_shifter_r <= parity_on ? {2'b11, tx_par_bit, transmit_buffer_r[6:0], 1'b0}
                                                : {3'b111, transmit_buffer_r[6:0], 1'b0};
          4'h9: transmit_shifter_r <= {1'b1, tx_ninth_bit, transmit_buffer_r, 1'b0};
          default: transmit_shifter_r <= parity_on ? {1'b1, tx_par_bit, transmit_buffer_r, 1'b0}
                                                   : {2'b11, transmit_buffer_r, 1'b0};
        endcase
        // start, data, parity, one or two stops
        tx_left_r <= data_len + {3'h0, parity_on} + {3'h0, int_clock_r[`IC_TWO_STOP]} + 4'h1;
        tx_busy_r <= 1'b1;
        tx_os_r <= 5'h00;
        tx_empty_r <= 1'b1;
        transmit_data_pin_o <= 1'b0;
      end
      else if (tx_busy_r && tx_edge)
      begin
        if (sync_mode || tx_os_r == 5'h0f)
        begin
          tx_os_r <= 5'h00;
          transmit_shifter_r <= {1'b1, transmit_shifter_r[10:1]};
          transmit_data_pin_o <= transmit_shifter_r[1];
          if (tx_left_r == 4'h0)
          begin
            tx_busy_r <= 1'b0;
            transmit_data_pin_o <= 1'b1;
          end
          else
            tx_left_r <= tx_left_r - 4'h1;
        end
        else
          tx_os_r <= tx_os_r + 5'h01; // divide by 16 when asynchronous
      end
    end
  end

  // receiver
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rx_full_r <= 1'b0;
      rx_ninth_bit_r <= 1'b0;
      overrun_r <= 1'b0;
      framing_r <= 1'b0;
      parity_err_r <= 1'b0;
      receive_buffer_r <= 8'h00;
      receive_shifter_r <= 10'h000;
      rx_left_r <= 4'h0;
      rx_os_r <= 5'h00;
      rx_votes_r <= 3'b111;
      rx_active_r <= 1'b0;
    end
    else if (halt_enter_i)
    begin
      // clear read-only status, keep buffers and shifter
      rx_full_r <= 1'b0;
      rx_ninth_bit_r <= 1'b0;
      overrun_r <= 1'b0;
      framing_r <= 1'b0;
      parity_err_r <= 1'b0;
      rx_active_r <= 1'b0;
    end
    else
    begin
      if (stat_read)
      begin
        overrun_r <= 1'b0;
        framing_r <= 1'b0;
        parity_err_r <= 1'b0;
      end
      if (receive_buffer_read)
        rx_full_r <= 1'b0;
      if (!rx_active_r && rx_edge && !receive_data_pin_i)
      begin
        // low seen; async rechecks at half bit
        rx_active_r <= 1'b1;
        rx_os_r <= 5'h00;
        receive_shifter_r <= 10'h000;
        rx_left_r <= sync_mode ? rx_len - 4'h1 : rx_len;
      end
      else if (rx_active_r && rx_edge)
      begin
        rx_os_r <= (sync_mode || rx_os_r == 5'h0f) ? 5'h00 : rx_os_r + 5'h01;
        if (!sync_mode && rx_os_r >= 5'h06 && rx_os_r <= 5'h08)
          rx_votes_r <= {rx_votes_r[1:0], receive_data_pin_i};
        if (!sync_mode && rx_left_r == rx_len && rx_os_r == 5'h07 && receive_data_pin_i)
          rx_active_r <= 1'b0;
        else if (sync_mode || rx_os_r == 5'h0f)
        begin
          if (rx_left_r == rx_len)
            rx_left_r <= rx_left_r - 4'h1;
          else if (rx_left_r != 4'h0)
          begin
            receive_shifter_r <= (receive_shifter_r >> 1) | ({9'h000, rx_bit} << (rx_len - 4'h2));
            rx_left_r <= rx_left_r - 4'h1;
          end
          else
          begin
            // one stop bit ends the frame
            rx_active_r <= 1'b0;
            if (!rx_bit)
              framing_r <= 1'b1;
            if (rx_full_r && !receive_buffer_read)
              overrun_r <= 1'b1;
            rx_full_r <= 1'b1;
            receive_buffer_r <= rx_data;
            if (nine_bits)
              rx_ninth_bit_r <= receive_shifter_r[8];
            if (parity_on && (seven_bits ? receive_shifter_r[7] : receive_shifter_r[8]) != rx_par_bit)
              parity_err_r <= 1'b1;
          end
        end
      end
    end
  end
endmodule
